// ### core/frot_pkg.sv
// Package with the register map, field layout and bus carrier of the overflow timer.
package frot_pkg;

    localparam int FROT_AW = 16;
    localparam int FROT_DW = 16;
    localparam int FROT_CW = 16;
    localparam int FROT_PW = 7;
    localparam int FROT_SW = 3;

    localparam logic [FROT_AW-1:0] FROT_ADDR_MODE = 16'hff80;
    localparam logic [FROT_AW-1:0] FROT_ADDR_CTRL = 16'hff81;
    localparam logic [FROT_AW-1:0] FROT_ADDR_IEN = 16'hff82;
    localparam logic [FROT_AW-1:0] FROT_ADDR_STAT = 16'hff83;
    localparam logic [FROT_AW-1:0] FROT_ADDR_ICLR = 16'hff84;
    localparam logic [FROT_AW-1:0] FROT_ADDR_CNT = 16'hff86;

    localparam int FROT_BIT_RUN = 7;
    localparam int FROT_BIT_OVF = 7;
    localparam int FROT_BIT_OVERFLOW_IRQ_ENABLE = 7;
    localparam int FROT_SEL_LO = 4;
    localparam int FROT_SEL_HI = 6;

    localparam logic FROT_RST_RUN = 1'b0;
    localparam logic [FROT_SW-1:0] FROT_RST_SEL = 3'h0;
    localparam logic FROT_RST_OVERFLOW_IRQ_ENABLE = 1'b0;
    localparam logic FROT_RST_OVF = 1'b0;
    localparam logic [FROT_CW-1:0] FROT_RST_CNT = 16'h0000;
    localparam logic [FROT_PW-1:0] FROT_RST_PRE = 7'h00;
    localparam logic [FROT_DW-1:0] FROT_RD_ZERO = 16'h0000;
    localparam logic [FROT_CW-1:0] FROT_CNT_ONE = 16'h0001;
    localparam logic [FROT_CW-1:0] FROT_CNT_MAX = 16'hffff;
    localparam logic [FROT_PW-1:0] FROT_PRE_ONE = 7'h01;
    localparam logic [FROT_PW:0] FROT_MASK_ONE = 8'h01;

    typedef struct packed {
        logic [FROT_AW-1:0] addr;
        logic [FROT_DW-1:0] wdata;
        logic wr;
        logic rd;
    } frot_bus_req_t;

endpackage

// ### core/frot_timer.sv
// Free-running 16-bit overflow timer with prescaler, register port and interrupt.
// Function
// - Run bit in mode register bit 7 lets counter advance; cleared, counter holds.
// - Control bits 6..4 pick the divider; value 010 divides system clock by four.
// - Interrupt enable bit 7 gates the overflow interrupt request.
// - Status bit 7 is set on counter overflow and holds until cleared; other bits read 0.
// - Counter is a 16-bit up-counter, one step per prescaled tick while running.
module frot_timer
    import frot_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire frot_bus_req_t bus_req,
    output logic [FROT_DW-1:0] rdata,
    output logic irq
);

    // Tick mask for a divide-by-two-to-the-sel prescaler.
    function automatic logic [FROT_PW-1:0] frot_div_mask(input logic [FROT_SW-1:0] sel);
        logic [FROT_PW:0] full;
        full = (FROT_MASK_ONE << sel) - FROT_MASK_ONE;
        return full[FROT_PW-1:0];
    endfunction

    // Address match of a strobed access.
    function automatic logic frot_hit(input logic [FROT_AW-1:0] a, input logic [FROT_AW-1:0] r);
        return a == r;
    endfunction

    logic run_reg;
    logic run_next;
    logic [FROT_SW-1:0] sel_reg;
    logic [FROT_SW-1:0] sel_next;
    logic overflow_irq_enable_reg;
    logic overflow_irq_enable_next;
    logic ovf_reg;
    logic ovf_next;
    logic [FROT_CW-1:0] cnt_reg;
    logic [FROT_CW-1:0] cnt_next;
    logic [FROT_PW-1:0] pre_reg;
    logic [FROT_PW-1:0] pre_next;
    logic [FROT_DW-1:0] rdata_reg;
    logic [FROT_DW-1:0] rdata_next;
    logic irq_reg;
    logic irq_next;

    wire logic wr_mode;
    wire logic wr_ctrl;
    wire logic wr_ien;
    wire logic wr_stat;
    wire logic wr_iclr;
    wire logic wr_cnt;
    wire logic [FROT_PW-1:0] div_mask;
    wire logic tick;
    wire logic step;
    wire logic wrap;
    wire logic ovf_clear;
    wire logic [FROT_DW-1:0] mode_view;
    wire logic [FROT_DW-1:0] ctrl_view;
    wire logic [FROT_DW-1:0] ien_view;
    wire logic [FROT_DW-1:0] stat_view;
    wire logic [FROT_DW-1:0] rd_sel;

    // Register write decode.
    assign wr_mode = bus_req.wr && frot_hit(bus_req.addr, FROT_ADDR_MODE);
    assign wr_ctrl = bus_req.wr && frot_hit(bus_req.addr, FROT_ADDR_CTRL);
    assign wr_ien = bus_req.wr && frot_hit(bus_req.addr, FROT_ADDR_IEN);
    assign wr_stat = bus_req.wr && frot_hit(bus_req.addr, FROT_ADDR_STAT);
    assign wr_iclr = bus_req.wr && frot_hit(bus_req.addr, FROT_ADDR_ICLR);
    assign wr_cnt = bus_req.wr && frot_hit(bus_req.addr, FROT_ADDR_CNT);

    assign run_next = wr_mode ? bus_req.wdata[FROT_BIT_RUN] : run_reg;
    assign sel_next = wr_ctrl ? bus_req.wdata[FROT_SEL_HI:FROT_SEL_LO] : sel_reg;
    assign overflow_irq_enable_next = wr_ien ? bus_req.wdata[FROT_BIT_OVERFLOW_IRQ_ENABLE] : overflow_irq_enable_reg;

    // The prescaler runs only while counting and holds its value when stopped, so a restart resumes the partial period.
    assign div_mask = frot_div_mask(sel_reg);
    assign tick = (pre_reg & div_mask) == div_mask;
    assign step = run_reg && tick;
    assign pre_next = run_reg ? pre_reg + FROT_PRE_ONE : pre_reg;

    // A software write to the counter wins over a step in the same cycle.
    assign wrap = step && !wr_cnt && (cnt_reg == FROT_CNT_MAX);
    assign cnt_next = wr_cnt ? bus_req.wdata[FROT_CW-1:0] :
                      step ? cnt_reg + FROT_CNT_ONE : cnt_reg;

    // Clear by writing 0 to the status flag, or 1 to the clear register; a wrap wins.
    assign ovf_clear = (wr_stat && !bus_req.wdata[FROT_BIT_OVF]) ||
                       (wr_iclr && bus_req.wdata[FROT_BIT_OVF]);
    assign ovf_next = wrap || (ovf_reg && !ovf_clear);

    assign irq_next = ovf_next && overflow_irq_enable_next;

    // Read view of each register; unused bits read as zero.
    assign mode_view = FROT_RD_ZERO | (FROT_DW'(run_reg) << FROT_BIT_RUN);
    assign ctrl_view = FROT_RD_ZERO | (FROT_DW'(sel_reg) << FROT_SEL_LO);
    assign ien_view = FROT_RD_ZERO | (FROT_DW'(overflow_irq_enable_reg) << FROT_BIT_OVERFLOW_IRQ_ENABLE);
    assign stat_view = FROT_RD_ZERO | (FROT_DW'(ovf_reg) << FROT_BIT_OVF);

    assign rd_sel = !bus_req.rd ? FROT_RD_ZERO :
                    frot_hit(bus_req.addr, FROT_ADDR_MODE) ? mode_view :
                    frot_hit(bus_req.addr, FROT_ADDR_CTRL) ? ctrl_view :
                    frot_hit(bus_req.addr, FROT_ADDR_IEN) ? ien_view :
                    frot_hit(bus_req.addr, FROT_ADDR_STAT) ? stat_view :
                    frot_hit(bus_req.addr, FROT_ADDR_CNT) ? cnt_reg :
                    FROT_RD_ZERO;
    assign rdata_next = rd_sel;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_reg <= FROT_RST_RUN;
            sel_reg <= FROT_RST_SEL;
            overflow_irq_enable_reg <= FROT_RST_OVERFLOW_IRQ_ENABLE;
        end else begin
            run_reg <= run_next;
            sel_reg <= sel_next;
            overflow_irq_enable_reg <= overflow_irq_enable_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= FROT_RST_CNT;
            pre_reg <= FROT_RST_PRE;
            ovf_reg <= FROT_RST_OVF;
        end else begin
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
            ovf_reg <= ovf_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= FROT_RD_ZERO;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;

endmodule // frot_timer

// ### sim/frot_timer_checker.sv
// Checker of read timing, register layout and interrupt gating of the overflow timer.
module frot_timer_checker
    import frot_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire frot_bus_req_t bus_req,
    input wire logic [FROT_DW-1:0] rdata,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence rd_at(logic [FROT_AW-1:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    a_rdata_idle: assert property (!bus_req.rd |=> rdata == FROT_RD_ZERO)
        else $error("read data not zero after idle cycle");
    a_run_layout: assert property (rd_at(FROT_ADDR_MODE) |=> (rdata & 16'hff7f) == 16'h0000)
        else $error("mode read shows bits other than run");
    a_sel_layout: assert property (rd_at(FROT_ADDR_CTRL) |=> (rdata & 16'hff8f) == 16'h0000)
        else $error("control read shows bits outside divider field");
    a_en_off: assert property (bus_req.wr && bus_req.addr == FROT_ADDR_IEN
        && !bus_req.wdata[FROT_BIT_OVERFLOW_IRQ_ENABLE]
        |=> !irq)
        else $error("interrupt stays high with enable cleared");
    a_flag_irq: assert property (rd_at(FROT_ADDR_STAT) ##0 irq |=> rdata == 16'h0080)
        else $error("status flag not set while interrupt high");
    a_irq_hold: assert property (irq && !bus_req.wr |=> irq)
        else $error("interrupt dropped without a write");
endmodule // frot_timer_checker
bind frot_timer frot_timer_checker frot_timer_checker_i (.clk(clk), .arst_n(arst_n),
    .bus_req(bus_req), .rdata(rdata), .irq(irq));

// ### sim/test_free_running_overflow_timer.sv
// Testbench of the overflow timer: reset values, divider, overflow and interrupt gating.
module test_free_running_overflow_timer
    import frot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    frot_bus_req_t bus_req = '0;
    logic [FROT_DW-1:0] rdata;
    logic irq;
    int n_mismatch = 0;
    int total_checks = 0;
    frot_timer frot_timer_i (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .irq(irq));
    always #12.5 clk = ~clk;
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] exp);
        bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(negedge clk);
        chk("rdata", rdata, exp);
        @(posedge clk);
    endtask
    task automatic irq_is(logic e);
        @(negedge clk);
        chk("irq", {15'h0000, irq}, {15'h0000, e});
        @(posedge clk);
    endtask
    task automatic t_reset();
        rd(FROT_ADDR_MODE, 16'h0000);
        rd(FROT_ADDR_CTRL, 16'h0000);
        rd(FROT_ADDR_IEN, 16'h0000);
        rd(FROT_ADDR_STAT, 16'h0000);
        rd(16'hff85, 16'h0000);
    endtask
    task automatic t_div();
        wr(FROT_ADDR_CTRL, 16'h0020);
        rd(FROT_ADDR_CTRL, 16'h0020);
        wr(FROT_ADDR_MODE, 16'h0080);
        repeat (38) @(posedge clk);
        wr(FROT_ADDR_MODE, 16'h0000);
        repeat (10) @(posedge clk);
        rd(FROT_ADDR_CNT, 16'h000a);
    endtask
    task automatic t_ovf();
        wr(FROT_ADDR_CTRL, 16'h0000);
        wr(FROT_ADDR_IEN, 16'h0080);
        wr(FROT_ADDR_CNT, 16'hfffe);
        wr(FROT_ADDR_MODE, 16'h0080);
        irq_is(1'b0);
        irq_is(1'b1);
        wr(FROT_ADDR_MODE, 16'h0000);
        rd(FROT_ADDR_CNT, 16'h0002);
        rd(FROT_ADDR_STAT, 16'h0080);
        wr(FROT_ADDR_IEN, 16'h0000);
        irq_is(1'b0);
        wr(FROT_ADDR_IEN, 16'h0080);
        irq_is(1'b1);
        wr(FROT_ADDR_STAT, 16'h0000);
        irq_is(1'b0);
        rd(FROT_ADDR_STAT, 16'h0000);
    endtask
    task automatic t_clear();
        wr(FROT_ADDR_CNT, 16'hffff);
        wr(FROT_ADDR_MODE, 16'h0080);
        irq_is(1'b1);
        wr(FROT_ADDR_MODE, 16'h0000);
        wr(FROT_ADDR_STAT, 16'h0080);
        rd(FROT_ADDR_STAT, 16'h0080);
        wr(FROT_ADDR_ICLR, 16'h0080);
        rd(FROT_ADDR_STAT, 16'h0000);
        irq_is(1'b0);
        rd(FROT_ADDR_ICLR, 16'h0000);
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_div();
        t_ovf();
        t_clear();
        end_of_test();
    end
endmodule // test_free_running_overflow_timer
